// file: core/uabd_top.sv
// Purpose: autobaud measurement and baud generation of the serial port unit
// Assumes: clk 20 MHz, 8-bit register port, read data one cycle later
// Notes: receive pin passes two flip-flops before any logic reads it
`include "uabd_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module uabd_top
  import uabd_pkg::*;
(
  input wire logic clk, // System clock, 20 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic [2:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic rx_pin, // Receive line, asynchronous
  input wire logic [7:0] rx_byte, // Byte from receive datapath
  input wire logic rx_byte_valid, // Receive datapath byte done
  output logic baud_tick, // Normal baud clock pulse
  output logic rx_hold_idle, // Hold receiver state machine idle
  output logic measuring, // Measurement running, from start bit to fifth rise
  output logic receive_complete_flag, // Receive-complete flag
  output logic [7:0] tx_data, // Transmit buffer contents
  output logic tx_load // Transmit buffer written pulse
);
  uabd_state_t s_q;
  uabd_state_t s_d;
  logic rise;
  logic fall;
  logic meas_tick;
  logic meas_clr;
  logic [9:0] meas_period;
  logic [16:0] baud_period;
  logic baud_clr;
  logic fifth;
  logic [16:0] inc;
  logic active;
  logic sw_ctrl;
  logic sw_start;

  // Edges are taken from the second synchroniser stage only
  assign rise = s_q.rx_s2 && !s_q.rx_prev;
  assign fall = !s_q.rx_s2 && s_q.rx_prev;

  // The sequence runs in any state other than idle
  assign active = (s_q.st != S_IDLE);

  // One-eighth rate
  // The table rates are already the eighth of the normal counter clock
  // Counter clock select
  always_comb begin
    unique case ({s_q.wide, s_q.hs})
      2'b00: meas_period = `UABD_MDIV_00;
      2'b11: meas_period = `UABD_MDIV_11;
      default: meas_period = `UABD_MDIV_MID;
    endcase
  end

  // Phase restart
  // Restarting at the first rise keeps the count aligned to the edge
  assign meas_clr = (s_q.st == S_RISE1) && rise;

  // Measurement tick divider
  uabd_tick_div #(.W(10)) u_meas (
    .clk(clk),
    .rstn(rstn),
    .clr(meas_clr),
    .period_m1(meas_period),
    .tick(meas_tick)
  );

  // Normal baud generation
  // Tick every divisor+1 cycles: x64 of the bit rate for select 00,
  // x16 for 01 and 10; in 8-bit modes only the low byte counts
  // Measured divisor reuse
  always_comb begin
    if (s_q.wide) begin
      baud_period = {1'b0, s_q.div};
    end else begin
      baud_period = {9'h000, s_q.div[7:0]};
    end
  end

  // The generator is reversed while measuring, so keep it in reset
  assign baud_clr = active || s_q.sync;

  // Normal baud divider
  uabd_tick_div #(.W(17)) u_baud (
    .clk(clk),
    .rstn(rstn),
    .clr(baud_clr),
    .period_m1(baud_period),
    .tick(baud_tick)
  );

  // Software decodes
  assign sw_ctrl = wr && (addr == `UABD_ADDR_CTRL);
  assign sw_start = sw_ctrl && wdata[`UABD_BIT_AUTOBAUD_ENABLE] && !s_q.autobaud_enable;

  assign fifth = (s_q.st == S_MEAS) && rise &&
    (s_q.edges == `UABD_EDGES_DONE);

  // Counter increment with carry out of the top bit
  assign inc = {1'b0, s_q.div} + 17'h00001;

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    s_d.txl = 1'b0;

    // Two-stage synchroniser, then the edge history
    s_d.rx_s1 = rx_pin;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.rx_prev = s_q.rx_s2;

    // Control register write
    if (sw_ctrl) begin
      s_d.autobaud_enable = wdata[`UABD_BIT_AUTOBAUD_ENABLE];
      s_d.wake_on_break_enable = wdata[`UABD_BIT_WUE];
      s_d.hs = wdata[`UABD_BIT_HS];
      s_d.wide = wdata[`UABD_BIT_WIDE];
      s_d.sync = wdata[`UABD_BIT_SYNC];
      s_d.ovf = wdata[`UABD_BIT_OVF];
    end

    // Divisor writes only land while no sequence owns the counter
    if (wr && !active && addr == `UABD_ADDR_DIVLO) begin
      s_d.div[7:0] = wdata;
    end
    if (wr && !active && addr == `UABD_ADDR_DIVHI) begin
      s_d.div[15:8] = wdata;
    end

    // Transmit buffer write
    // Transmit lockout
    // The baud clock is reversed, so the write is dropped, not queued
    if (wr && addr == `UABD_ADDR_TXBUF && !s_q.autobaud_enable) begin
      s_d.txd = wdata;
      s_d.txl = 1'b1;
    end

    if (rd && addr == `UABD_ADDR_RXBUF) begin
      s_d.rcf = 1'b0;
    end

    // A finished byte from the normal receiver sets the flag
    if (rx_byte_valid && !active) begin
      s_d.rcf = 1'b1;
    end

    // Detection sequence
    unique case (s_q.st)
      S_IDLE: begin
        s_d.edges = 3'h0;
      end
      S_BRK_LOW: begin
        if (fall || !s_q.rx_s2) begin
          s_d.st = S_BRK_HIGH;
        end
      end
      S_BRK_HIGH: begin
        // End of break: wake-on-break is done, measure the next byte
        if (rise) begin
          s_d.wake_on_break_enable = 1'b0;
          s_d.st = S_START;
        end
      end
      S_START: begin
        if (fall) begin
          s_d.st = S_RISE1;
        end
      end
      S_RISE1: begin
        if (rise) begin
          s_d.edges = 3'h1;
          s_d.st = S_MEAS;
        end
      end
      S_MEAS: begin
        // Low and high bits
        // Counting spans both levels of eight bits, so asymmetry cancels
        if (meas_tick) begin
          s_d.div = inc[15:0];
          if (inc[16]) begin
            s_d.ovf = 1'b1;
          end
        end
        if (rise) begin
          s_d.edges = s_q.edges + 3'h1;
        end
        if (fifth) begin
          s_d.autobaud_enable = 1'b0;
          s_d.rcf = 1'b1;
          s_d.st = S_IDLE;
        end
      end
    endcase

    // Async and wake-on-break
    // Leaving async mode or dropping enable aborts any sequence
    if (active && (s_d.sync || !s_d.autobaud_enable) && !fifth) begin
      s_d.st = S_IDLE;
    end

    if (sw_start && !wdata[`UABD_BIT_SYNC]) begin
      s_d.div = `UABD_DIV_RST;
      s_d.edges = 3'h0;
      if (wdata[`UABD_BIT_WUE]) begin
        s_d.st = S_BRK_LOW;
      end else begin
        s_d.st = S_START;
      end
    end

    // Read data register, answered in the cycle after the strobe
    s_d.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        `UABD_ADDR_CTRL: begin
          s_d.rdata[`UABD_BIT_AUTOBAUD_ENABLE] = s_q.autobaud_enable;
          s_d.rdata[`UABD_BIT_WUE] = s_q.wake_on_break_enable;
          s_d.rdata[`UABD_BIT_HS] = s_q.hs;
          s_d.rdata[`UABD_BIT_WIDE] = s_q.wide;
          s_d.rdata[`UABD_BIT_SYNC] = s_q.sync;
          s_d.rdata[`UABD_BIT_HOLD] = active;
          s_d.rdata[`UABD_BIT_OVF] = s_q.ovf;
        end
        `UABD_ADDR_DIVLO: begin
          s_d.rdata = s_q.div[7:0];
        end
        `UABD_ADDR_DIVHI: begin
          s_d.rdata = s_q.div[15:8];
        end
        `UABD_ADDR_RXBUF: begin
          // Value is meaningless after detection and is to be discarded
          s_d.rdata = rx_byte;
        end
        `UABD_ADDR_TXBUF: begin
          s_d.rdata = s_q.txd;
        end
        `UABD_ADDR_STAT: begin
          s_d.rdata[`UABD_BIT_RCF] = s_q.rcf;
          s_d.rdata[`UABD_BIT_MEAS] = active;
          s_d.rdata[`UABD_BIT_BRK] = (s_q.st == S_BRK_LOW) ||
            (s_q.st == S_BRK_HIGH);
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register; every field resets to zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign rdata = s_q.rdata;
  assign rx_hold_idle = active;
  assign measuring = (s_q.st == S_MEAS) || (s_q.st == S_RISE1);
  assign receive_complete_flag = s_q.rcf;
  assign tx_data = s_q.txd;
  assign tx_load = s_q.txl;
endmodule
`default_nettype wire

// file: core/uabd_consts.svh
// What this block does
// - Measure only in asynchronous mode, with or without wake-on-break enable.
// - Setting autobaud enable clears the counter, then waits for a start bit.
// - Start bit with enable set begins measurement; the result averages over the character.
// - The baud counter becomes a timer run by the receive line.
// - Measure across both low and high bit times against asymmetry.
// - Counting starts at the first rising receive edge after the start bit.
// - At the fifth rising edge the divisor pair holds the bit period.
// - The fifth rising edge clears autobaud enable automatically.
// - Counter wrap FFFFh to 0000h sets overflow flag, control bit 7.
// - Hardware sets the overflow flag; software may set or clear it.
// - Rollover does not end detection; enable stays set.
// - Measuring clock is one eighth of the configured counter clock.
// - Selects 00 give Fosc/512, 01 and 10 Fosc/128, 11 Fosc/32.
// - Full 16-bit counting; software checks high byte 00h in 8-bit modes.
// - The receive state machine is held idle during detection.
// - The fifth rising edge sets the receive-complete flag.
// - Reading the receive buffer clears that flag; software discards the value.
// - With wake-on-break also set, measure the character after the break.
// - Normal baud clock runs at 4, 16 or 64 times the bit rate.
//
// Purpose: register map, field positions, reset values and divider counts
// Assumes: 8-bit register port, 3-bit address
// Notes: reset values are all zero
`ifndef UABD_CONSTS_SVH
`define UABD_CONSTS_SVH
`define UABD_ADDR_CTRL 3'h0
`define UABD_ADDR_DIVLO 3'h1
`define UABD_ADDR_DIVHI 3'h2
`define UABD_ADDR_RXBUF 3'h3
`define UABD_ADDR_TXBUF 3'h4
`define UABD_ADDR_STAT 3'h5
`define UABD_BIT_AUTOBAUD_ENABLE 0
`define UABD_BIT_WUE 1
`define UABD_BIT_HS 2
`define UABD_BIT_WIDE 3
`define UABD_BIT_SYNC 5
`define UABD_BIT_HOLD 6
`define UABD_BIT_OVF 7
`define UABD_BIT_RCF 0
`define UABD_BIT_MEAS 1
`define UABD_BIT_BRK 2
`define UABD_CTRL_RST 8'h00
`define UABD_DIV_RST 16'h0000
`define UABD_MDIV_00 10'h1FF
`define UABD_MDIV_MID 10'h07F
`define UABD_MDIV_11 10'h01F
`define UABD_EDGES_DONE 3'h4
`endif

// file: core/uabd_pkg.sv
// Purpose: shared types of the autobaud block
// Assumes: constants come from the header
// Notes: the whole state of the top is one packed struct
package uabd_pkg;
  typedef enum logic [2:0] {
    S_IDLE,
    S_BRK_LOW,
    S_BRK_HIGH,
    S_START,
    S_RISE1,
    S_MEAS
  } uabd_fsm_t;

  typedef struct packed {
    uabd_fsm_t st;
    logic autobaud_enable;
    logic wake_on_break_enable;
    logic hs;
    logic wide;
    logic sync;
    logic ovf;
    logic rcf;
    logic [15:0] div;
    logic [2:0] edges;
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    logic [7:0] rdata;
    logic [7:0] txd;
    logic txl;
  } uabd_state_t;
endpackage

// file: core/uabd_tick_div.sv
// Purpose: free-running divider giving one-cycle ticks
// Assumes: period_m1 is the tick period minus one
// Notes: clr restarts the phase so the next tick is a full period away
`timescale 1ns/100ps
`default_nettype none
module uabd_tick_div #(
  parameter int W = 10
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic clr, // Restart phase
  input wire logic [W-1:0] period_m1, // Period minus one
  output logic tick // One-cycle tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Wrap at the period; a period change applies at once to the running count
  always_comb begin
    tick = (cnt_q >= period_m1) && !clr;
    if (clr || cnt_q >= period_m1) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  // Phase register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// file: tb/uabd_monitor.sv
// Purpose: port-level checks of the autobaud block
// Assumes: sees only the top ports, one clock domain
// Notes: bound into every instance of the top
`timescale 1ns/100ps
`default_nettype none
module uabd_monitor (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic [2:0] addr, // Register address
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic rx_byte_valid, // Datapath byte done
  input wire logic baud_tick, // Normal baud pulse
  input wire logic rx_hold_idle, // Receiver held idle
  input wire logic measuring, // Measurement phase running
  input wire logic receive_complete_flag, // Receive flag
  input wire logic tx_load // Transmit buffer loaded
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Receiver stays idle for the whole measurement
  a_hold_while_meas: assert property (measuring |-> rx_hold_idle)
    else $error("receiver not held during measurement");
  // Counter is a timer here, so no baud pulses
  a_no_tick_held: assert property (rx_hold_idle && $past(rx_hold_idle) |-> !baud_tick)
    else $error("baud pulse while sequence runs");
  a_meas_after_wait: assert property ($rose(measuring) |-> $past(rx_hold_idle))
    else $error("measurement began without start wait");
  // A sequence that ends without a write ended on the fifth rise
  a_end_sets_flag: assert property ($fell(measuring) && !$past(wr) |-> receive_complete_flag && !rx_hold_idle)
    else $error("measurement end without flag");
  a_flag_cause: assert property ($rose(receive_complete_flag) |-> $past(rx_byte_valid) || $fell(measuring))
    else $error("receive flag set without cause");
  a_flag_stays_set: assert property (receive_complete_flag && !(rd && addr == 3'h3) |=> receive_complete_flag)
    else $error("receive flag lost without buffer read");
  a_flag_read_clear: assert property (rd && addr == 3'h3 && !rx_byte_valid && !measuring |=> !receive_complete_flag)
    else $error("buffer read left receive flag set");
  a_tx_refused: assert property (tx_load |-> $past(wr) && $past(addr) == 3'h4 && !$past(rx_hold_idle))
    else $error("transmit load without accepted write");
  a_hold_end_cause: assert property ($fell(rx_hold_idle) |-> receive_complete_flag || $past(wr))
    else $error("sequence ended without fifth rise");
endmodule

bind uabd_top uabd_monitor i_mon (
  .clk(clk), .rstn(rstn), .addr(addr), .wr(wr), .rd(rd),
  .rx_byte_valid(rx_byte_valid), .baud_tick(baud_tick),
  .rx_hold_idle(rx_hold_idle), .measuring(measuring),
  .receive_complete_flag(receive_complete_flag), .tx_load(tx_load)
);
`default_nettype wire

// file: tb/uabd_rx_model.sv
// Purpose: remote sender on the receive line
// Assumes: line idles high between frames
// Notes: bit length in clock cycles is chosen per call
`timescale 1ns/100ps
`default_nettype none
module uabd_rx_model (
  input wire logic clk, // System clock
  output logic rx // Serial line to the block
);
  initial rx = 1'h1;

  task automatic send(input logic [7:0] b, input int t);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    // Start, eight bits low first, stop
    for (int i = 0; i < 10; i++) begin
      rx <= f[i];
      repeat (t) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/uabd_top_tb.sv
// Purpose: self-checking bench of the autobaud block
// Assumes: 20 MHz clock, sender model on the receive line
// Notes: 1010-cycle bits keep every count clear of a tick boundary
`timescale 1ns/100ps
`default_nettype none
module uabd_top_tb;
  logic clk, rstn, wr, rd, rxv, tick, hold, meas, rcf, txl;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rxb, txd;
  logic [15:0] ex;
  wire logic rx;
  int num_errors, cmp_count, n;

  uabd_top i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_pin(rx), .rx_byte(rxb), .rx_byte_valid(rxv), .baud_tick(tick),
    .rx_hold_idle(hold), .measuring(meas), .receive_complete_flag(rcf), .tx_data(txd), .tx_load(txl));
  uabd_rx_model i_rx (.clk(clk), .rx(rx));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bchk(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  // Data is looked at in the one cycle where it stands
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, e});
  endtask

  // Cycles between two baud pulses, bounded
  task automatic tick_gap(output int c);
    c = 0;
    while (tick !== 1'h1 && c < 999) begin
      @(negedge clk);
      c++;
    end
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (tick !== 1'h1 && c < 999);
  endtask

  task automatic test_done;
    $display("Counts: %0d mismatches, %0d comparisons", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Run needs near 61000 cycles; half as much again is allowed
  initial begin
    #4600000;
    num_errors++;
    test_done;
  end

  initial begin
    rstn = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    addr = 3'h0;
    wdata = 8'h00;
    rxb = 8'hA5;
    rxv = 1'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    rchk(3'h0, 8'h00);
    rchk(3'h2, 8'h00);
    rchk(3'h6, 8'h00);
    $display("reset test done");
    @(posedge clk);
    rxv <= 1'h1;
    @(posedge clk);
    rxv <= 1'h0;
    rchk(3'h5, 8'h01); // flag in status
    rchk(3'h3, 8'hA5); // buffer read
    bchk(rcf, 1'h0); // flag cleared
    wreg(3'h0, 8'h80);
    rchk(3'h0, 8'h80); // software set
    wreg(3'h0, 8'h00);
    rchk(3'h0, 8'h00); // software clear
    wreg(3'h1, 8'h5A);
    wreg(3'h0, 8'h21);
    rchk(3'h1, 8'h5A); // sync mode keeps divisor
    bchk(hold, 1'h0); // receiver not held
    wreg(3'h0, 8'h00);
    $display("register test done");
    // One character per counter clock select; 8 bits of 1010 cycles
    for (int m = 0; m < 4; m++) begin
      ex = 16'(8080 / (m == 0 ? 512 : (m == 3 ? 32 : 128)));
      wreg(3'h0, {4'h0, 2'(m), 2'h1}); // no transmission running
      rchk(3'h1, 8'h00); // counter cleared
      bchk(hold, 1'h1); // receiver held
      bchk(meas, 1'h0); // waiting for start bit
      rchk(3'h0, {4'h4, 2'(m), 2'h1}); // held bit in control
      wreg(3'h4, 8'h3C);
      @(negedge clk);
      bchk(txl, 1'h0); // no load while enabled
      i_rx.send(8'h55, 1010);
      bchk(rcf, 1'h1); // flag at stop bit
      rchk(3'h0, {4'h0, 2'(m), 2'h0}); // enable cleared
      rchk(3'h1, ex[7:0]); // low byte
      rchk(3'h2, ex[15:8]); // high byte
      rchk(3'h3, 8'hA5); // discarded read
      bchk(rcf, 1'h0); // flag cleared
    end
    $display("measure test done");
    chk({8'h00, txd}, 16'h0000); // write refused
    wreg(3'h4, 8'h96);
    @(negedge clk);
    bchk(txl, 1'h1); // load after accepted write
    tick_gap(n);
    chk(16'(n), 16'h00FD); // measured rate
    chk({8'h00, txd}, 16'h0096); // write accepted
    wreg(3'h0, 8'h0F); // wide select with autobaud
    rchk(3'h5, 8'h06); // waiting for break
    i_rx.send(8'h00, 1010);
    i_rx.send(8'h55, 1010);
    rchk(3'h0, 8'h0C); // both enables cleared
    rchk(3'h1, 8'hFC); // character after break
    $display("break test done");
    test_done;
  end
endmodule
`default_nettype wire
